// ==== adc_low_voltage_conv_timing_test.sv ====
// Self-checking testbench of the low-voltage conversion timing sequencer
`timescale 1ns/100ps
module adc_low_voltage_conv_timing_test import adc_lv_timing_pkg::*;;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic        clock_i      = 1'b0;
  logic        rst_i        = 1'b1;
  logic [7:0]  reg_addr_i   = 8'h00;
  logic [31:0] reg_wdata_i  = 32'h0;
  logic        reg_wr_i     = 1'b0;
  logic        reg_rd_i     = 1'b0;
  logic        hw_trigger_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        irq_o;
  logic        conv_busy_o;
  logic        conv_end_o;
  int          mismatches   = 0;
  int          n_compared   = 0;

  adc_lv_conv_timing uut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .hw_trigger_i(hw_trigger_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .conv_busy_o(conv_busy_o), .conv_end_o(conv_end_o));

  always #25 clock_i = ~clock_i;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check(what, reg_rdata_o, exp);
  endtask

  task automatic wait_end(input int limit, inout int n);
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (conv_end_o !== 1'b1 && n < limit);
  endtask

  // Mode fields move only after a full halt and the settle wait
  task automatic halt_set(input logic [31:0] m);
    wr(OFF_CTRL, 32'h0);
    repeat (HALT_WAIT_CLK + 1) @(posedge clock_i);
    wr(OFF_MODE, m);
    wr(OFF_STAT, 32'h3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rdc(OFF_CTRL, 32'h0, "ctrl_rst");
    rdc(OFF_MODE, 32'h10, "mode_rst");
    rdc(OFF_STAT, 32'h0, "stat_rst");
    rdc(OFF_MASK, 32'h0, "mask_rst");
    // Cycle count runs free while idle: nine edges have passed since reset left
    rdc(OFF_STATE, 32'h0000_0901, "state_rst");
    rdc(8'h14, 32'h0, "unmapped");
    @(posedge clock_i);
    #1;
    check("rdata_drop", reg_rdata_o, 32'h0);
    wr(OFF_MASK, 32'h1);
    rdc(OFF_MASK, 32'h1, "mask_wr");
    $display("test reset finished");
  endtask

  task automatic t_one_shot(input logic [2:0] c, input int d, input int tot);
    int n;
    n = 2;
    halt_set({27'h0, LVM1, c});
    wr(OFF_CTRL, 32'h0B);
    repeat (2) @(posedge clock_i);
    #1;
    check("busy_rise", 32'(conv_busy_o), 32'h1);
    wait_end(tot + d + 50, n);
    check("oneshot_len", 32'(n), 32'(tot + d + 1));
    check("busy_end", 32'(conv_busy_o), 32'h0);
    @(posedge clock_i);
    #1;
    check("irq_set", 32'(irq_o), 32'h1);
    rdc(OFF_STAT, 32'h1, "done_set");
    rdc(OFF_CTRL, 32'h0A, "run_clear");
    wr(OFF_STAT, 32'h1);
    repeat (2) @(posedge clock_i);
    #1;
    check("irq_clear", 32'(irq_o), 32'h0);
    $display("test one-shot divider %0d finished", d);
  endtask

  task automatic t_refuse;
    halt_set(32'h17);
    wr(OFF_MODE, 32'h12);
    wr(OFF_MODE, 32'h07);
    rdc(OFF_MODE, 32'h17, "illegal_keep");
    rdc(OFF_STAT, 32'h2, "illegal_err");
    wr(OFF_STAT, 32'h3);
    wr(OFF_CTRL, 32'h03);
    wr(OFF_MODE, 32'h16);
    rdc(OFF_MODE, 32'h17, "run_keep");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h3);
    wr(OFF_MODE, 32'h16);
    rdc(OFF_MODE, 32'h17, "settle_keep");
    rdc(OFF_STAT, 32'h2, "settle_err");
    repeat (HALT_WAIT_CLK + 1) @(posedge clock_i);
    wr(OFF_MODE, 32'h16);
    rdc(OFF_MODE, 32'h16, "halted_take");
    $display("test refusals finished");
  endtask

  // An internal target at the undivided clock exceeds the limit and must not start
  task automatic t_internal;
    int n;
    n = 0;
    halt_set(32'h17);
    wr(OFF_CTRL, 32'h1B);
    repeat (4) @(posedge clock_i);
    #1;
    check("int_no_start", 32'(conv_busy_o), 32'h0);
    rdc(OFF_STAT, 32'h2, "int_err");
    halt_set(32'h1E);
    wr(OFF_CTRL, 32'h1B);
    wait_end(1000, n);
    check("int_len", 32'(n), 32'd863);
    $display("test internal target finished");
  endtask

  task automatic t_hw;
    int n;
    n = 2;
    halt_set(32'h17);
    wr(OFF_CTRL, 32'h07);
    repeat (10) @(posedge clock_i);
    #1;
    check("hw_wait", 32'(conv_busy_o), 32'h0);
    @(posedge clock_i);
    hw_trigger_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    hw_trigger_i <= 1'b0;
    wait_end(600, n);
    // Three synchroniser stages put the take edge four edges after the pin rises
    check("hw_len", 32'(n), 32'd435);
    @(posedge clock_i);
    #1;
    check("hw_idle", 32'(conv_busy_o), 32'h0);
    $display("test hardware trigger finished");
  endtask

  task automatic t_cont;
    int n;
    n = 0;
    halt_set(32'h17);
    wr(OFF_CTRL, 32'h03);
    wait_end(600, n);
    check("first_len", 32'(n), 32'd432);
    n = 0;
    wait_end(600, n);
    check("next_len", 32'(n), 32'd430);
    repeat (100) @(posedge clock_i);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h3);
    n = 0;
    wait_end(500, n);
    check("abort_no_end", 32'(n), 32'd500);
    rdc(OFF_STAT, 32'h0, "abort_no_done");
    check("abort_idle", 32'(conv_busy_o), 32'h0);
    $display("test continuous finished");
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Tests need about 20000 cycles; the 45000-cycle watchdog, over twice that, leaves margin
  initial begin
    repeat (45000) @(posedge clock_i);
    mismatches++;
    $display("BAD watchdog expected finish seen hang");
    results;
  end

  initial begin
    logic [2:0] codes[4];
    int         divs[4];
    int         tots[4];
    codes = '{DIV1, DIV2, DIV16, DIV32};
    divs  = '{1, 2, 16, 32};
    tots  = '{430, 860, 5152, 10304};
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset;
    for (int i = 0; i < 4; i++) begin
      t_one_shot(codes[i], divs[i], tots[i]);
    end
    t_refuse;
    t_internal;
    t_hw;
    t_cont;
    results;
  end
endmodule

// ==== adc_lv_conv_timing.sv ====
// Low-voltage no-wait conversion timing sequencer with register port
//
// Functional notes
// - Divide-by-two clock: conversion totals 860 clocks
// - Undivided clock: conversion totals 430 clocks
// - Divider: /32, /16, /2, /1; others refused
// - First conversion adds the start time
// - Counts hold for software and hardware triggers
`timescale 1ns/100ps
module adc_lv_conv_timing
  import adc_lv_timing_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        hw_trigger_i,
  output logic      [31:0] reg_rdata_o,
  output logic             irq_o,
  output logic             conv_busy_o,
  output logic             conv_end_o
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  conv_ctrl_s  ctrl_ff;
  conv_mode_s  mode_ff;
  phase_e      phase_ff;
  phase_e      nxt_phase;
  logic [1:0]  status_ff;
  logic [1:0]  mask_ff;
  logic [5:0]  presc_ff;
  logic [9:0]  fad_cnt_ff;
  logic [13:0] cyc_ff;
  logic [13:0] first_cyc_ff;
  logic        first_ff;
  logic [2:0]  halt_cnt_ff;
  logic        trig_s1_ff;
  logic        trig_s2_ff;
  logic        trig_s3_ff;
  logic        trig_lvl_ff;
  logic        trig_edge;
  logic        tick;
  logic        active;
  logic        start_ok;
  logic        start_err;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        mode_change;
  logic        mode_ok;
  logic        conv_done;
  conv_mode_s  wr_mode_val;

  assign wr_ctrl     = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign wr_mode     = reg_wr_i && (reg_addr_i == OFF_MODE);
  assign wr_mode_val = conv_mode_s'(reg_wdata_i[4:0]);
  assign mode_change = wr_mode && (wr_mode_val != mode_ff);
  assign active      = ctrl_ff.conversion_run_bit && ctrl_ff.comparator_enable_bit;
  assign tick        = (presc_ff == fad_div(mode_ff.conv_clock_divider_select) - 6'd1);
  assign trig_edge   = trig_lvl_ff == 1'b0 && trig_s2_ff && trig_s3_ff;
  // A new value is taken only when halted, settled and legal
  assign mode_ok     = !ctrl_ff.conversion_run_bit && !ctrl_ff.comparator_enable_bit
                       && (halt_cnt_ff == 3'd0)
                       && div_legal(wr_mode_val.conv_clock_divider_select)
                       && (wr_mode_val.conv_voltage_mode_select inside {LVM1, LVM2});
  assign start_err   = ctrl_ff.internal_target
                       && (mode_ff.conv_voltage_mode_select != LVM2
                           || !fad_ok(mode_ff.conv_clock_divider_select));
  assign start_ok    = phase_ff == PH_IDLE && active && !start_err
                       && (ctrl_ff.hw_trigger_mode ? trig_edge : 1'b1);
  assign conv_done   = phase_ff == PH_IRQD && tick && active;

  // ****************************************************************
  // Hardware trigger synchroniser
  // ****************************************************************
  // Level only moves once the second and third stage agree
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      trig_s1_ff  <= 1'b0;
      trig_s2_ff  <= 1'b0;
      trig_s3_ff  <= 1'b0;
      trig_lvl_ff <= 1'b0;
    end else begin
      trig_s1_ff <= hw_trigger_i;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
      if (trig_s2_ff == trig_s3_ff) begin
        trig_lvl_ff <= trig_s3_ff;
      end
    end
  end

  // ****************************************************************
  // Control and mode registers
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= conv_ctrl_s'(CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_ff <= conv_ctrl_s'(reg_wdata_i[4:0]);
    end else if (conv_done && !ctrl_ff.hw_trigger_mode && ctrl_ff.one_shot) begin
      ctrl_ff.conversion_run_bit <= 1'b0;
    end
  end

  // Settling timer restarts every cycle that the converter is not halted
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      halt_cnt_ff <= 3'd0;
    end else if (ctrl_ff.conversion_run_bit || ctrl_ff.comparator_enable_bit) begin
      halt_cnt_ff <= 3'(HALT_WAIT_CLK);
    end else if (halt_cnt_ff != 3'd0) begin
      halt_cnt_ff <= halt_cnt_ff - 3'd1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= conv_mode_s'(MODE_RST);
    end else if (mode_change && mode_ok) begin
      mode_ff <= wr_mode_val;
    end
  end

  // ****************************************************************
  // Status, mask and interrupt
  // ****************************************************************
  // Hardware set wins over a same-cycle write-one clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= STAT_RST;
    end else begin
      status_ff[ST_DONE] <= conv_done
        || (status_ff[ST_DONE] && !(reg_wr_i && reg_addr_i == OFF_STAT && reg_wdata_i[ST_DONE]));
      status_ff[ST_ERR] <= (mode_change && !mode_ok)
        || (phase_ff == PH_IDLE && active && start_err)
        || (status_ff[ST_ERR] && !(reg_wr_i && reg_addr_i == OFF_STAT && reg_wdata_i[ST_ERR]));
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_ff <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == OFF_MASK) begin
      mask_ff <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_ff & mask_ff);
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_IDLE: begin
        if (start_ok) begin
          nxt_phase = PH_FIRST;
        end
      end
      PH_FIRST: begin
        if (tick && fad_cnt_ff == 10'(FIRST_START_FAD - 1)) begin
          nxt_phase = PH_START;
        end
      end
      PH_START: begin
        if (tick && fad_cnt_ff == 10'(START_FAD - 1)) begin
          nxt_phase = PH_CONV;
        end
      end
      PH_CONV: begin
        if (tick && fad_cnt_ff == conv_fad(mode_ff.conv_clock_divider_select) - 10'd1) begin
          nxt_phase = PH_IRQD;
        end
      end
      PH_IRQD: begin
        if (tick && fad_cnt_ff == 10'(IRQ_FAD - 1)) begin
          nxt_phase = (!ctrl_ff.hw_trigger_mode && !ctrl_ff.one_shot) ? PH_START : PH_IDLE;
        end
      end
    endcase
    // Halting mid-conversion abandons the result
    if (!active) begin
      nxt_phase = PH_IDLE;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Prescaler derives the conversion clock tick from the system clock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      presc_ff <= 6'd0;
    end else if (phase_ff == PH_IDLE || tick) begin
      presc_ff <= 6'd0;
    end else begin
      presc_ff <= presc_ff + 6'd1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fad_cnt_ff <= 10'd0;
    end else if (nxt_phase != phase_ff) begin
      fad_cnt_ff <= 10'd0;
    end else if (tick) begin
      fad_cnt_ff <= fad_cnt_ff + 10'd1;
    end
  end

  // Cycle counts per conversion; cyc_ff is readable for software profiling, first_cyc_ff only feeds the assertions
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_ff       <= 14'd0;
      first_cyc_ff <= 14'd0;
      first_ff     <= 1'b0;
    end else begin
      cyc_ff       <= (nxt_phase == PH_START && phase_ff != PH_START) ? 14'd0 : cyc_ff + 14'd1;
      first_cyc_ff <= (phase_ff == PH_IDLE) ? 14'd0 : first_cyc_ff + 14'd1;
      if (phase_ff == PH_IDLE) begin
        first_ff <= 1'b1;
      end else if (conv_done) begin
        first_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      conv_busy_o <= 1'b0;
      conv_end_o  <= 1'b0;
    end else begin
      conv_busy_o <= nxt_phase != PH_IDLE;
      conv_end_o  <= conv_done;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_CTRL:  reg_rdata_o <= {27'h0, ctrl_ff};
        OFF_MODE:  reg_rdata_o <= {27'h0, mode_ff};
        OFF_STAT:  reg_rdata_o <= {30'h0, status_ff};
        OFF_MASK:  reg_rdata_o <= {30'h0, mask_ff};
        OFF_STATE: reg_rdata_o <= {10'h0, cyc_ff, 3'h0, phase_ff};
        default:   reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_DIV_LEGAL: assert property (div_legal(mode_ff.conv_clock_divider_select))
    else $error("Divider holds a prohibited code");
  AST_MODE_HALTED: assert property ($changed(mode_ff) |-> $past(ctrl_ff.conversion_run_bit) == 1'b0
    && $past(ctrl_ff.comparator_enable_bit) == 1'b0) else $error("Mode changed while not halted");
  AST_MODE_SETTLED: assert property ($changed(mode_ff) |-> $past(halt_cnt_ff) == 3'd0)
    else $error("Mode changed before settling time");
  AST_TOTAL_DIV2: assert property (conv_done && mode_ff.conv_clock_divider_select == DIV2
    |-> cyc_ff + 14'd1 == 14'(TOTAL_DIV2)) else $error("Divide-by-two conversion length wrong");
  AST_TOTAL_DIV1: assert property (conv_done && mode_ff.conv_clock_divider_select == DIV1
    |-> cyc_ff + 14'd1 == 14'(TOTAL_DIV1)) else $error("Undivided conversion length wrong");
  AST_FIRST_LEN: assert property (conv_done && first_ff |-> first_cyc_ff + 14'd1
    == total_clk(mode_ff.conv_clock_divider_select)
       + 14'(FIRST_START_FAD * int'(fad_div(mode_ff.conv_clock_divider_select))))
    else $error("First conversion lacks start time");
  AST_HW_START: assert property (phase_ff == PH_IDLE && nxt_phase == PH_FIRST
    && ctrl_ff.hw_trigger_mode |-> trig_edge) else $error("Hardware start without trigger");
  AST_TARGET: assert property (phase_ff == PH_IDLE && nxt_phase == PH_FIRST && ctrl_ff.internal_target
    |-> mode_ff.conv_voltage_mode_select == LVM2) else $error("Internal target needs voltage mode 2");
  AST_IRQ_DONE: assert property (conv_done ##1 mask_ff[ST_DONE] |-> ##1 irq_o)
    else $error("Completion interrupt missing");
  AST_END_PULSE: assert property (conv_end_o |-> $past(phase_ff) == PH_IRQD && !$past(conv_end_o))
    else $error("End pulse without output delay");

  COV_SEQ: cover property (conv_done ##[1:900] conv_done);
  COV_HW: cover property (ctrl_ff.hw_trigger_mode && conv_done);
  COV_REFUSED: cover property (mode_change && !mode_ok);
endmodule

// ==== adc_lv_timing_pkg.sv ====
// Constants, types and helpers of the low-voltage conversion timing block
package adc_lv_timing_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int HALT_WAIT_NS    = 200;
  localparam int HALT_WAIT_CLK   = (HALT_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FAD_MAX_HZ      = 16_000_000;
  localparam int START_FAD       = 1;
  localparam int IRQ_FAD         = 1;
  localparam int FIRST_START_FAD = 1;
  localparam int TOTAL_DIV32     = 10304;
  localparam int TOTAL_DIV16     = 5152;
  localparam int TOTAL_DIV2      = 860;
  localparam int TOTAL_DIV1      = 430;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_MODE  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_MASK  = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;
  localparam int ST_DONE = 0;
  localparam int ST_ERR  = 1;
  localparam int STATE_CYC_POS = 8;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [2:0] DIV32 = 3'h0;
  localparam logic [2:0] DIV16 = 3'h1;
  localparam logic [2:0] DIV2  = 3'h6;
  localparam logic [2:0] DIV1  = 3'h7;
  localparam logic [1:0] LVM1  = 2'h2;
  localparam logic [1:0] LVM2  = 2'h3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [4:0] MODE_RST = {LVM1, DIV32};
  localparam logic [1:0] STAT_RST = 2'h0;

  typedef struct packed {
    logic [1:0] conv_voltage_mode_select;
    logic [2:0] conv_clock_divider_select;
  } conv_mode_s;

  typedef struct packed {
    logic internal_target;
    logic one_shot;
    logic hw_trigger_mode;
    logic comparator_enable_bit;
    logic conversion_run_bit;
  } conv_ctrl_s;

  typedef enum logic [4:0] {
    PH_IDLE  = 5'b00001,
    PH_FIRST = 5'b00010,
    PH_START = 5'b00100,
    PH_CONV  = 5'b01000,
    PH_IRQD  = 5'b10000
  } phase_e;

  function automatic logic [5:0] fad_div(input logic [2:0] c);
    case (c)
      DIV32:   fad_div = 6'd32;
      DIV16:   fad_div = 6'd16;
      DIV2:    fad_div = 6'd2;
      default: fad_div = 6'd1;
    endcase
  endfunction

  function automatic logic [13:0] total_clk(input logic [2:0] c);
    case (c)
      DIV32:   total_clk = 14'(TOTAL_DIV32);
      DIV16:   total_clk = 14'(TOTAL_DIV16);
      DIV2:    total_clk = 14'(TOTAL_DIV2);
      default: total_clk = 14'(TOTAL_DIV1);
    endcase
  endfunction

  function automatic logic [9:0] conv_fad(input logic [2:0] c);
    conv_fad = 10'(int'(total_clk(c)) / int'(fad_div(c)) - START_FAD - IRQ_FAD);
  endfunction

  function automatic logic div_legal(input logic [2:0] c);
    div_legal = (c == DIV32) || (c == DIV16) || (c == DIV2) || (c == DIV1);
  endfunction

  function automatic logic fad_ok(input logic [2:0] c);
    fad_ok = (CLK_HZ / int'(fad_div(c))) <= FAD_MAX_HZ;
  endfunction
endpackage
